// >>> adctc_pkg.sv
`default_nettype none
package adctc_pkg;
    localparam logic [11:0] ADDR_CTRL0    = 12'h000;
    localparam logic [11:0] ADDR_CTRL1    = 12'h004;
    localparam logic [11:0] ADDR_RES_HIGH = 12'h008;
    localparam logic [11:0] ADDR_RES_LOW  = 12'h00c;
    localparam logic [11:0] ADDR_FIXREF   = 12'h010;
    localparam logic [11:0] ADDR_GUARD    = 12'h014;
    localparam int          CTRL0_ENABLE  = 0;
    localparam int          CTRL0_START   = 1;
    localparam int          CTRL1_FORMAT  = 7;
    localparam int          FIXREF_RANGE  = 4;
    localparam int          FIXREF_TEMP_SENSOR_ENABLE   = 5;
    localparam int          FIXREF_READY  = 6;
    localparam int          FIXREF_FVREN  = 7;
    localparam logic [7:0]  CTRL0_MASK    = 8'h7f;
    localparam logic [7:0]  CTRL1_MASK    = 8'hf7;
    localparam logic [4:0]  CHAN_TEMP     = 5'h1d;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int          CLK_MHZ       = 25;
    localparam int          TEMP_WAIT_US  = 200;
    localparam int          TEMP_WAIT_CYC = TEMP_WAIT_US * CLK_MHZ;
    localparam int          CONV_CYC      = 12;
    typedef enum logic [1:0] {
        ADCTC_IDLE = 2'b00,
        ADCTC_CONV = 2'b01,
        ADCTC_DONE = 2'b11
    } adctc_state_type;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } adctc_wr_type;
endpackage
`default_nettype wire

// >>> adctc_top.sv
`timescale 1ns/1ns
`default_nettype none
module adctc_top #(
    parameter int TEMP_WAIT = adctc_pkg::TEMP_WAIT_CYC,
    parameter int CONV_LEN  = adctc_pkg::CONV_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic [1:0]       s_axi_bresp_out,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [11:0] s_axi_araddr_in,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    input  wire logic [9:0]  sample_data_in,
    output logic [4:0]       channel_select_out,
    output logic             converter_enable_out,
    output logic             sample_out,
    output logic             temp_sensor_enable_out,
    output logic             temp_range_select_out,
    output logic             temp_channel_active_out,
    output logic             temp_settled_out
);
    logic [7:0] ctrl0_reg, ctrl1_reg, res_high_reg, res_low_reg, fixref_reg;
    logic [7:0] res_high_next, res_low_next;
    logic       aw_full_reg, w_full_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        guard_err_reg;
    adctc_pkg::adctc_state_type state_reg;
    logic [15:0] conv_cnt_reg;
    logic [31:0] settle_cnt_reg;

    // write channels taken independently, response after both
    assign s_axi_awready_out = !aw_full_reg && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_full_reg && !s_axi_bvalid_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    wire   do_write   = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
    wire   wr_lane0   = do_write && w_strb_reg[0];
    wire   sel_c0     = aw_addr_reg == adctc_pkg::ADDR_CTRL0;
    wire   sel_c1     = aw_addr_reg == adctc_pkg::ADDR_CTRL1;
    wire   sel_rh     = aw_addr_reg == adctc_pkg::ADDR_RES_HIGH;
    wire   sel_rl     = aw_addr_reg == adctc_pkg::ADDR_RES_LOW;
    wire   sel_fr     = aw_addr_reg == adctc_pkg::ADDR_FIXREF;
    wire   wr_mapped  = sel_c0 | sel_c1 | sel_rh | sel_rl | sel_fr;
    wire   [7:0] wbyte = w_data_reg[7:0];
    wire   busy       = state_reg != adctc_pkg::ADCTC_IDLE;
    wire   temp_sel   = ctrl0_reg[6:2] == adctc_pkg::CHAN_TEMP;
    wire   settled    = settle_cnt_reg >= 32'(TEMP_WAIT);
    // start while converter is on; early temperature start is flagged
    wire   start_req  = wr_lane0 && sel_c0 && wbyte[adctc_pkg::CTRL0_START]
                        && ctrl0_reg[adctc_pkg::CTRL0_ENABLE] && !busy;
    wire   conv_end   = state_reg == adctc_pkg::ADCTC_CONV
                        && conv_cnt_reg == 16'(CONV_LEN - 1);
    wire   fmt_right  = ctrl1_reg[adctc_pkg::CTRL1_FORMAT];

    always_comb begin
        if (fmt_right) begin
            res_high_next = {6'h00, sample_data_in[9:8]};
            res_low_next  = sample_data_in[7:0];
        end else begin
            res_high_next = sample_data_in[9:2];
            res_low_next  = {sample_data_in[1:0], 6'h00};
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= adctc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr_in[11:2], 2'b00};
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (wr_mapped || aw_addr_reg == adctc_pkg::ADDR_GUARD)
                                    ? adctc_pkg::RESP_OKAY : adctc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl0_reg    <= adctc_pkg::RESET_BYTE;
            ctrl1_reg    <= adctc_pkg::RESET_BYTE;
            res_high_reg <= adctc_pkg::RESET_BYTE;
            res_low_reg  <= adctc_pkg::RESET_BYTE;
            fixref_reg   <= adctc_pkg::RESET_BYTE;
        end else begin
            if (wr_lane0 && sel_c0) begin
                ctrl0_reg[6:2] <= wbyte[6:2];
                ctrl0_reg[0]   <= wbyte[0];
            end
            // hardware owns the clear, software only sets it
            if (start_req)
                ctrl0_reg[adctc_pkg::CTRL0_START] <= 1'b1;
            else if (conv_end)
                ctrl0_reg[adctc_pkg::CTRL0_START] <= 1'b0;
            if (wr_lane0 && sel_c1)
                ctrl1_reg <= wbyte & adctc_pkg::CTRL1_MASK;
            if (conv_end) begin
                res_high_reg <= res_high_next;
                res_low_reg  <= res_low_next;
            end else begin
                if (wr_lane0 && sel_rh)
                    res_high_reg <= wbyte;
                if (wr_lane0 && sel_rl)
                    res_low_reg <= wbyte;
            end
            if (wr_lane0 && sel_fr)
                fixref_reg <= {wbyte[7], 1'b0, wbyte[5:0]};
            fixref_reg[adctc_pkg::FIXREF_READY] <= fixref_reg[adctc_pkg::FIXREF_FVREN];
        end
    end

    // conversion sequencer; the guard counter measures sensor settle time
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg      <= adctc_pkg::ADCTC_IDLE;
            conv_cnt_reg   <= 16'h0000;
            settle_cnt_reg <= 32'h0000_0000;
            guard_err_reg  <= 1'b0;
        end else begin
            case (state_reg)
                adctc_pkg::ADCTC_IDLE: begin
                    conv_cnt_reg <= 16'h0000;
                    if (start_req)
                        state_reg <= adctc_pkg::ADCTC_CONV;
                end
                adctc_pkg::ADCTC_CONV: begin
                    conv_cnt_reg <= conv_cnt_reg + 16'h0001;
                    if (conv_end)
                        state_reg <= adctc_pkg::ADCTC_DONE;
                end
                adctc_pkg::ADCTC_DONE: state_reg <= adctc_pkg::ADCTC_IDLE;
                default: state_reg <= adctc_pkg::ADCTC_IDLE;
            endcase
            if (!temp_sel || (wr_lane0 && sel_c0 && wbyte[6:2] != ctrl0_reg[6:2]) || conv_end)
                settle_cnt_reg <= 32'h0000_0000;
            else if (!settled)
                settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
            if (start_req && temp_sel && !settled)
                guard_err_reg <= 1'b1;
            else if (wr_lane0 && aw_addr_reg == adctc_pkg::ADDR_GUARD && wbyte[0])
                guard_err_reg <= 1'b0;
        end
    end

    wire [11:0] raddr = {s_axi_araddr_in[11:2], 2'b00};
    wire [7:0]  rbyte = raddr == adctc_pkg::ADDR_CTRL0 ? ctrl0_reg & adctc_pkg::CTRL0_MASK :
                        raddr == adctc_pkg::ADDR_CTRL1 ? ctrl1_reg :
                        raddr == adctc_pkg::ADDR_RES_HIGH ? res_high_reg :
                        raddr == adctc_pkg::ADDR_RES_LOW ? res_low_reg :
                        raddr == adctc_pkg::ADDR_FIXREF ? fixref_reg :
                        {6'h00, settled, guard_err_reg};
    wire        rmapped = raddr <= adctc_pkg::ADDR_GUARD;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= adctc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rmapped ? {24'h000000, rbyte} : 32'h0000_0000;
            s_axi_rresp_out  <= rmapped ? adctc_pkg::RESP_OKAY : adctc_pkg::RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    assign channel_select_out      = ctrl0_reg[6:2];
    assign converter_enable_out    = ctrl0_reg[adctc_pkg::CTRL0_ENABLE];
    assign sample_out              = state_reg == adctc_pkg::ADCTC_CONV;
    assign temp_sensor_enable_out  = fixref_reg[adctc_pkg::FIXREF_TEMP_SENSOR_ENABLE];
    assign temp_range_select_out   = fixref_reg[adctc_pkg::FIXREF_RANGE];
    assign temp_channel_active_out = temp_sel && temp_sensor_enable_out;
    assign temp_settled_out        = settled;

    // register bus answers
    wr_err_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        do_write && !wr_mapped && aw_addr_reg != adctc_pkg::ADDR_GUARD
        |=> s_axi_bvalid_out && s_axi_bresp_out == adctc_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    rd_err_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_axi_arvalid_in && s_axi_arready_out && !rmapped
        |=> s_axi_rresp_out == adctc_pkg::RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
        else $error("unmapped read not refused");

    // conversion sequencing
    start_sets_busy_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        start_req
        |=> ctrl0_reg[adctc_pkg::CTRL0_START] && state_reg == adctc_pkg::ADCTC_CONV)
        else $error("start did not begin conversion");
    conv_clears_go_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        conv_end
        |=> !ctrl0_reg[adctc_pkg::CTRL0_START] && state_reg == adctc_pkg::ADCTC_DONE)
        else $error("start bit not cleared at end");
    sample_go_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        sample_out
        |-> ctrl0_reg[adctc_pkg::CTRL0_START])
        else $error("start bit low while converting");
    idle_go_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_reg == adctc_pkg::ADCTC_IDLE && !start_req
        |=> !ctrl0_reg[adctc_pkg::CTRL0_START])
        else $error("start bit set while idle");
    off_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && sel_c0 && wbyte[adctc_pkg::CTRL0_START] && !converter_enable_out && !busy
        |=> !sample_out && !ctrl0_reg[adctc_pkg::CTRL0_START])
        else $error("start taken while converter off");
    conv_len_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        start_req
        |=> ##[1:300] conv_end)
        else $error("conversion too long");
    results_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !conv_end && !(wr_lane0 && (sel_rh || sel_rl))
        |=> $stable(res_high_reg) && $stable(res_low_reg))
        else $error("result bytes changed outside load");

    // result layout
    right_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        conv_end && fmt_right
        |=> res_high_reg == {6'h00, $past(sample_data_in[9:8])})
        else $error("right high byte wrong");
    right_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        conv_end && fmt_right
        |=> res_low_reg == $past(sample_data_in[7:0]))
        else $error("right low byte wrong");
    left_fmt_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        conv_end && !fmt_right
        |=> res_low_reg == {$past(sample_data_in[1:0]), 6'h00}
        && res_high_reg == $past(sample_data_in[9:2]))
        else $error("left format wrong");

    // temperature channel
    temp_sensor_enable_on_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && sel_fr && wbyte[adctc_pkg::FIXREF_TEMP_SENSOR_ENABLE]
        |=> temp_sensor_enable_out)
        else $error("sensor not powered when enabled");
    temp_sensor_enable_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && sel_fr && !wbyte[adctc_pkg::FIXREF_TEMP_SENSOR_ENABLE]
        |=> !temp_sensor_enable_out && !temp_channel_active_out)
        else $error("sensor powered while disabled");
    range_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && sel_fr
        |=> temp_range_select_out == $past(wbyte[adctc_pkg::FIXREF_RANGE]))
        else $error("range bit not applied");
    temp_chan_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        temp_channel_active_out
        |-> channel_select_out == adctc_pkg::CHAN_TEMP)
        else $error("temp routed on wrong channel");
    early_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        start_req && temp_sel && !settled
        |=> guard_err_reg)
        else $error("early start not flagged");
    guard_clr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && aw_addr_reg == adctc_pkg::ADDR_GUARD && wbyte[0]
        |=> !guard_err_reg)
        else $error("early start flag not cleared");
    conv_settle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        conv_end
        |=> !temp_settled_out)
        else $error("settle time not restarted after conversion");
    chan_settle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_lane0 && sel_c0 && wbyte[6:2] != ctrl0_reg[6:2]
        |=> !temp_settled_out)
        else $error("settle time not restarted on channel change");
    ready_lag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        1'b1
        |=> fixref_reg[adctc_pkg::FIXREF_READY] == $past(fixref_reg[adctc_pkg::FIXREF_FVREN]))
        else $error("reference ready flag does not follow enable");

    // main scenarios
    conv_c: cover property (@(posedge clk_in) disable iff (!nrst_in) conv_end && fmt_right);
    left_c: cover property (@(posedge clk_in) disable iff (!nrst_in) conv_end && !fmt_right);
    temp_c: cover property (@(posedge clk_in) disable iff (!nrst_in) start_req && temp_sel);
    early_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
        start_req && temp_sel && !settled);
    settled_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
        start_req && temp_sel && settled);
endmodule
`default_nettype wire

// >>> adctc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module adctc_top_test;
    logic        clk_in  = 1'b0;
    logic        nrst_in = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bdy = 1'b0, arv = 1'b0, rdy = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd  = 32'h00000000;
    logic [9:0]  smp = 10'h2a5;
    logic        awr, wr, bv, arr, rv, cen, smo, tse, trs, tca, tst;
    logic [1:0]  br, rr;
    logic [31:0] rd;
    logic [4:0]  channel_select;
    int          num_errors = 0;
    int          checked    = 0;

    always #20 clk_in = ~clk_in;

    adctc_top #(.TEMP_WAIT(20), .CONV_LEN(8)) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bv), .s_axi_bready_in(bdy),
        .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rdy),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .sample_data_in(smp),
        .channel_select_out(channel_select), .converter_enable_out(cen), .sample_out(smo),
        .temp_sensor_enable_out(tse), .temp_range_select_out(trs),
        .temp_channel_active_out(tca), .temp_settled_out(tst));

    task automatic results;
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= {24'h000000, d}; bdy <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) begin
                chk({30'h0, br}, {30'h0, er});
                bdy <= 1'b0;
                break;
            end
            n++;
            if (n > 50) begin
                num_errors++;
                break;
            end
        end
        @(posedge clk_in);
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        arv <= 1'b1; ara <= a; rdy <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arv && arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) begin
                d = rd;
                chk({30'h0, rr}, {30'h0, er});
                rdy <= 1'b0;
                break;
            end
            n++;
            if (n > 50) begin
                num_errors++;
                break;
            end
        end
        @(posedge clk_in);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        rd_reg(a, d, adctc_pkg::RESP_OKAY);
        chk(d, {24'h000000, exp});
    endtask

    // start a conversion and poll the start bit until hardware clears it
    task automatic run_conv(input logic [7:0] c0);
        logic [31:0] d;
        int          n;
        n = 0;
        wr_reg(adctc_pkg::ADDR_CTRL0, c0, adctc_pkg::RESP_OKAY);
        @(negedge clk_in);
        chk({31'h0, smo}, 32'h1);
        @(posedge clk_in);
        rd_reg(adctc_pkg::ADDR_CTRL0, d, adctc_pkg::RESP_OKAY);
        chk({31'h0, d[1]}, 32'h1);
        while (d[1] !== 1'b0 && n < 40) begin
            rd_reg(adctc_pkg::ADDR_CTRL0, d, adctc_pkg::RESP_OKAY);
            n++;
        end
        chk({31'h0, d[1]}, 32'h0);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) rd_chk(12'(i * 4), 8'h00);
        rd_reg(12'h018, d, adctc_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        wr_reg(12'h018, 8'h5a, adctc_pkg::RESP_SLVERR);
        wr_reg(adctc_pkg::ADDR_CTRL0, 8'h82, adctc_pkg::RESP_OKAY);
        rd_chk(adctc_pkg::ADDR_CTRL0, 8'h00);
        wr_reg(adctc_pkg::ADDR_CTRL1, 8'hff, adctc_pkg::RESP_OKAY);
        rd_chk(adctc_pkg::ADDR_CTRL1, 8'hf7);
        wr_reg(adctc_pkg::ADDR_FIXREF, 8'h80, adctc_pkg::RESP_OKAY);
        rd_chk(adctc_pkg::ADDR_FIXREF, 8'hc0);
    endtask

    // software write to the low byte first, so the load is seen to replace it
    task automatic t_conv(input logic fmt, input logic [9:0] v);
        smp <= v;
        wr_reg(adctc_pkg::ADDR_CTRL1, {fmt, 7'h00}, adctc_pkg::RESP_OKAY);
        wr_reg(adctc_pkg::ADDR_RES_LOW, 8'h55, adctc_pkg::RESP_OKAY);
        rd_chk(adctc_pkg::ADDR_RES_LOW, 8'h55);
        wr_reg(adctc_pkg::ADDR_CTRL0, 8'h0d, adctc_pkg::RESP_OKAY);
        chk({31'h0, cen}, 32'h1);
        repeat (8) @(posedge clk_in);
        run_conv(8'h0f);
        if (fmt) begin
            rd_chk(adctc_pkg::ADDR_RES_HIGH, {6'h00, v[9:8]});
            rd_chk(adctc_pkg::ADDR_RES_LOW, v[7:0]);
        end else begin
            rd_chk(adctc_pkg::ADDR_RES_HIGH, v[9:2]);
            rd_chk(adctc_pkg::ADDR_RES_LOW, {v[1:0], 6'h00});
        end
    endtask

    task automatic t_temp;
        wr_reg(adctc_pkg::ADDR_FIXREF, 8'h30, adctc_pkg::RESP_OKAY);
        chk({30'h0, tse, trs}, 32'h3);
        wr_reg(adctc_pkg::ADDR_FIXREF, 8'h20, adctc_pkg::RESP_OKAY);
        chk({30'h0, tse, trs}, 32'h2);
        wr_reg(adctc_pkg::ADDR_CTRL0, 8'h75, adctc_pkg::RESP_OKAY);
        chk({27'h0, channel_select}, {27'h0, adctc_pkg::CHAN_TEMP});
        chk({30'h0, tca, tst}, 32'h2);
        run_conv(8'h77);
        rd_chk(adctc_pkg::ADDR_GUARD, 8'h01);
        wr_reg(adctc_pkg::ADDR_GUARD, 8'h01, adctc_pkg::RESP_OKAY);
        repeat (25) @(posedge clk_in);
        rd_chk(adctc_pkg::ADDR_GUARD, 8'h02);
        run_conv(8'h77);
        rd_chk(adctc_pkg::ADDR_GUARD, 8'h00);
        run_conv(8'h77);
        rd_chk(adctc_pkg::ADDR_GUARD, 8'h01);
        wr_reg(adctc_pkg::ADDR_FIXREF, 8'h00, adctc_pkg::RESP_OKAY);
        chk({29'h0, tse, trs, tca}, 32'h0);
    endtask

    initial begin
        #(40 * 20000);
        num_errors++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_conv(1'b1, 10'h2a5);
        t_conv(1'b0, 10'h2a5);
        t_conv(1'b1, 10'h15a);
        t_temp();
        results();
    end
endmodule
`default_nettype wire
